// *** core/rtcc_top.sv ***
// RTC source selection, internal RC oscillator with trim, and carrier
// frequency detection timed by the selected RTC.
// Assumes all pins are asynchronous to i_clk; control bits are static levels.
//
// Behaviour
// - Source select 1 takes crystal path, 0 takes internal RC oscillator.
// - Selected RTC times carrier frequency detection during wakeup evaluation.
// - Calibration starts on the RC trim direct command.
// - New trim applies from the 65th reference edge, held volatile.
// - Trim lost on power-on reset or RC off; host recalibrates.
`timescale 1ns/1ps
`include "rtcc_params.svh"

module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int unsigned RC_UNTRIMMED_CYC = `RTCC_RC_NOM_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_scl,
  input wire logic i_sdata,
  input wire logic i_crystal_input_pin,
  input wire logic i_carrier,
  input wire logic i_rtc_source_select_bit,
  input wire logic i_crystal_path_enable_bit,
  input wire logic i_power_down,
  input wire logic i_wake_eval,
  output logic o_rtc_tick,
  output logic o_rtc_clk,
  output logic o_rc_on,
  output logic o_trim_valid,
  output logic [`RTCC_TRIM_W-1:0] o_trim_period,
  output logic o_cal_busy,
  output logic o_freq_done,
  output logic o_freq_ok
);

  // ==========================================================
  // Pin synchronisers
  logic [`RTCC_PIN_N-1:0] pin_raw;
  logic [`RTCC_PIN_N-1:0] meta_q;
  logic [`RTCC_PIN_N-1:0] sync_q;
  logic [`RTCC_PIN_N-1:0] prev_q;
  logic [`RTCC_PIN_N-1:0] rise;

  assign pin_raw[`RTCC_PIN_CS] = i_cs;
  assign pin_raw[`RTCC_PIN_SCL] = i_scl;
  assign pin_raw[`RTCC_PIN_DAT] = i_sdata;
  assign pin_raw[`RTCC_PIN_XTAL] = i_crystal_input_pin;
  assign pin_raw[`RTCC_PIN_CAR] = i_carrier;

  genvar gi;
  generate
    for (gi = 0; gi < `RTCC_PIN_N; gi++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
      assign rise[gi] = sync_q[gi] & ~prev_q[gi];
    end
  endgenerate

  // ==========================================================
  // Calibration engine
  rtcc_cal_if cal_bus ();

  logic rc_on;

  // RC runs only when selected and the part is not powered down
  assign rc_on = ~i_rtc_source_select_bit & ~i_power_down;

  assign cal_bus.cs = sync_q[`RTCC_PIN_CS];
  assign cal_bus.sck_rise = rise[`RTCC_PIN_SCL];
  assign cal_bus.sdata = sync_q[`RTCC_PIN_DAT];
  assign cal_bus.clear = ~rc_on;

  rtcc_trim_cal u_cal (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .cal (cal_bus.cal)
  );

  // ==========================================================
  // Internal RC oscillator model
  // A period counter on i_clk; trimmed period replaces the untrimmed one
  localparam rtcc_trim_t RC_UNTRIM = rtcc_trim_t'(RC_UNTRIMMED_CYC);

  rtcc_trim_t rc_period;
  rtcc_trim_t rc_cnt_q, rc_cnt_d;
  logic rc_tick;

  assign rc_period = cal_bus.trim_valid ? cal_bus.trim_period : RC_UNTRIM;
  assign rc_tick = rc_on && (rc_cnt_q >= rc_period - rtcc_trim_t'(1));

  always_comb begin
    rc_cnt_d = rc_cnt_q;
    if (!rc_on || rc_tick) begin
      rc_cnt_d = '0;
    end else begin
      rc_cnt_d = rc_cnt_q + rtcc_trim_t'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rc_cnt_q <= '0;
    end else begin
      rc_cnt_q <= rc_cnt_d;
    end
  end

  // ==========================================================
  // RTC source selection
  // Crystal and external clock share the crystal path; without its enable
  // nothing toggles, and in power down the input is ignored as it sits high
  logic xtal_tick;
  logic rtc_tick;
  logic rtc_tick_q, rtc_tick_d;
  logic rtc_clk_q, rtc_clk_d;

  assign xtal_tick = i_rtc_source_select_bit & i_crystal_path_enable_bit &
                     ~i_power_down & rise[`RTCC_PIN_XTAL];
  assign rtc_tick = i_rtc_source_select_bit ? xtal_tick : rc_tick;

  always_comb begin
    rtc_tick_d = rtc_tick;
    rtc_clk_d = rtc_clk_q;
    if (rtc_tick) begin
      rtc_clk_d = ~rtc_clk_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rtc_tick_q <= 1'b0;
      rtc_clk_q <= 1'b0;
    end else begin
      rtc_tick_q <= rtc_tick_d;
      rtc_clk_q <= rtc_clk_d;
    end
  end

  // ==========================================================
  // Carrier frequency detection
  // Counts carrier edges in one RTC period; a carrier near four times the
  // RTC rate lands inside the window. The first window after evaluation
  // starts is partial, so its verdict is discarded.
  logic [`RTCC_FD_CNT_W-1:0] car_cnt_q, car_cnt_d;
  logic armed_q, armed_d;
  logic done_q, done_d;
  logic ok_q, ok_d;

  always_comb begin
    car_cnt_d = car_cnt_q;
    armed_d = armed_q;
    done_d = 1'b0;
    ok_d = ok_q;
    if (!i_wake_eval) begin
      car_cnt_d = '0;
      armed_d = 1'b0;
      ok_d = 1'b0;
    end else if (rtc_tick) begin
      // Window closes on the selected RTC period
      if (armed_q) begin
        done_d = 1'b1;
        ok_d = (car_cnt_q >= `RTCC_FD_MIN) && (car_cnt_q <= `RTCC_FD_MAX);
      end
      armed_d = 1'b1;
      car_cnt_d = rise[`RTCC_PIN_CAR] ? `RTCC_FD_CNT_W'(1) : '0;
    end else if (rise[`RTCC_PIN_CAR] && car_cnt_q != '1) begin
      car_cnt_d = car_cnt_q + `RTCC_FD_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      car_cnt_q <= '0;
      armed_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      car_cnt_q <= car_cnt_d;
      armed_q <= armed_d;
      done_q <= done_d;
      ok_q <= ok_d;
    end
  end

  // ==========================================================
  // Outputs
  logic rc_on_q;
  logic trim_valid_q;
  rtcc_trim_t trim_q;
  logic busy_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rc_on_q <= 1'b0;
      trim_valid_q <= 1'b0;
      trim_q <= '0;
      busy_q <= 1'b0;
    end else begin
      rc_on_q <= rc_on;
      trim_valid_q <= cal_bus.trim_valid;
      trim_q <= cal_bus.trim_period;
      busy_q <= cal_bus.busy;
    end
  end

  assign o_rtc_tick = rtc_tick_q;
  assign o_rtc_clk = rtc_clk_q;
  assign o_rc_on = rc_on_q;
  assign o_trim_valid = trim_valid_q;
  assign o_trim_period = trim_q;
  assign o_cal_busy = busy_q;
  assign o_freq_done = done_q;
  assign o_freq_ok = ok_q;

endmodule : rtcc_top

// *** core/rtcc_params.svh ***
// Timing, encoding and field constants of the RTC source and RC trim block.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

// ==========================================================
// Clock and RC oscillator timing
`define RTCC_CLK_FREQ_HZ 40000000
`define RTCC_RC_NOM_FREQ_HZ 32768
`define RTCC_RC_NOM_CYC (`RTCC_CLK_FREQ_HZ / `RTCC_RC_NOM_FREQ_HZ)

// ==========================================================
// Calibration sequence
`define RTCC_CMD_W 8
`define RTCC_CMD_RC_TRIM 8'hC2
`define RTCC_REF_EDGES 7'h41
`define RTCC_CAL_SHIFT 6
`define RTCC_TRIM_W 16
`define RTCC_CYC_W 22

// ==========================================================
// Carrier frequency detection window, carrier edges per RTC period
`define RTCC_FD_CNT_W 8
`define RTCC_FD_MIN 8'h03
`define RTCC_FD_MAX 8'h05

// ==========================================================
// Synchronised pin vector layout
`define RTCC_PIN_N 5
`define RTCC_PIN_CS 0
`define RTCC_PIN_SCL 1
`define RTCC_PIN_DAT 2
`define RTCC_PIN_XTAL 3
`define RTCC_PIN_CAR 4

`endif

// *** core/rtcc_pkg.sv ***
// Types shared by the RTC source and RC trim block.
// Assumes rtcc_params.svh is on the include path.
`include "rtcc_params.svh"

package rtcc_pkg;

  // ==========================================================
  // Calibration sequencer states
  typedef enum logic [1:0] {
    RTCC_CAL_IDLE = 2'b00,
    RTCC_CAL_CMD = 2'b01,
    RTCC_CAL_REF = 2'b10,
    RTCC_CAL_DONE = 2'b11
  } rtcc_cal_state_t;

  typedef logic [`RTCC_TRIM_W-1:0] rtcc_trim_t;

endpackage : rtcc_pkg

// *** core/rtcc_cal_if.sv ***
// Carrier between the RTC core and its RC calibration engine.
// Assumes all signals sit in the i_clk domain, pins already synchronised.
`timescale 1ns/1ps

interface rtcc_cal_if;
  import rtcc_pkg::*;
  logic cs;
  logic sck_rise;
  logic sdata;
  logic clear;
  logic trim_valid;
  logic busy;
  rtcc_trim_t trim_period;

  modport cal (input cs, input sck_rise, input sdata, input clear,
               output trim_valid, output busy, output trim_period);
  modport core (output cs, output sck_rise, output sdata, output clear,
                input trim_valid, input busy, input trim_period);
endinterface : rtcc_cal_if

// *** core/rtcc_trim_cal.sv ***
// RC oscillator calibration engine: decodes the trim command on the serial
// host interface and measures 64 reference periods between edges 1 and 65.
// Assumes synchronised chip select, data and a one-cycle serial clock rise.
`timescale 1ns/1ps
`include "rtcc_params.svh"

module rtcc_trim_cal
  import rtcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  rtcc_cal_if.cal cal
);

  rtcc_cal_state_t state_q, state_d;
  logic [`RTCC_CMD_W-1:0] cmd_q, cmd_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] edge_q, edge_d;
  logic [`RTCC_CYC_W-1:0] cyc_q, cyc_d;
  rtcc_trim_t trim_q, trim_d;
  logic valid_q, valid_d;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    bit_d = bit_q;
    edge_d = edge_q;
    cyc_d = cyc_q;
    trim_d = trim_q;
    valid_d = valid_q;
    unique case (state_q)
      RTCC_CAL_IDLE: begin
        // Chip select must already be high when the command starts
        if (cal.cs) begin
          state_d = RTCC_CAL_CMD;
          bit_d = 3'h0;
        end
      end
      RTCC_CAL_CMD: begin
        if (cal.sck_rise) begin
          cmd_d = {cmd_q[`RTCC_CMD_W-2:0], cal.sdata};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'(`RTCC_CMD_W - 1)) begin
            // Trim command opens the reference window, others are ignored
            if ({cmd_q[`RTCC_CMD_W-2:0], cal.sdata} == `RTCC_CMD_RC_TRIM) begin
              state_d = RTCC_CAL_REF;
              edge_d = 7'h0;
              cyc_d = '0;
            end else begin
              state_d = RTCC_CAL_DONE;
            end
          end
        end
      end
      RTCC_CAL_REF: begin
        if (edge_q != 7'h0) begin
          cyc_d = cyc_q + `RTCC_CYC_W'(1);
        end
        if (cal.sck_rise) begin
          edge_d = edge_q + 7'h1;
          // Trim takes effect on the 65th reference edge
          if (edge_q + 7'h1 == `RTCC_REF_EDGES) begin
            // Count includes this cycle, so edge 1 to edge 65 is exact
            trim_d = rtcc_trim_t'(cyc_d >> `RTCC_CAL_SHIFT);
            valid_d = 1'b1;
            state_d = RTCC_CAL_DONE;
          end
        end
      end
      RTCC_CAL_DONE: begin
        state_d = RTCC_CAL_DONE;
      end
    endcase
    // Falling chip select ends or aborts any sequence
    if (!cal.cs) begin
      state_d = RTCC_CAL_IDLE;
    end
    // Trim is volatile: lost when the RC oscillator stops
    if (cal.clear) begin
      valid_d = 1'b0;
      if (state_q == RTCC_CAL_REF) begin
        state_d = RTCC_CAL_DONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Power-on reset discards the trim
      state_q <= RTCC_CAL_IDLE;
      cmd_q <= '0;
      bit_q <= 3'h0;
      edge_q <= 7'h0;
      cyc_q <= '0;
      trim_q <= '0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      bit_q <= bit_d;
      edge_q <= edge_d;
      cyc_q <= cyc_d;
      trim_q <= trim_d;
      valid_q <= valid_d;
    end
  end

  assign cal.trim_valid = valid_q;
  assign cal.trim_period = trim_q;
  assign cal.busy = (state_q == RTCC_CAL_REF);

endmodule : rtcc_trim_cal

// *** sim/rtcc_top_assertions.sv ***
// Port-level checker of the RTC source and RC trim block.
// Assumes one i_clk domain with synchronous reset; bound after endmodule.
`timescale 1ns/1ps
`include "rtcc_params.svh"

module rtcc_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_rtc_source_select_bit,
  input wire logic i_crystal_path_enable_bit,
  input wire logic i_power_down,
  input wire logic i_wake_eval,
  input wire logic o_rtc_tick,
  input wire logic o_trim_valid,
  input wire logic [`RTCC_TRIM_W-1:0] o_trim_period,
  input wire logic o_cal_busy,
  input wire logic o_freq_done,
  input wire logic o_freq_ok
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ====
  // Held conditions; repeat counts cover the register stages to the outputs
  sequence s_rc_off;
    (i_rtc_source_select_bit || i_power_down) [*4];
  endsequence
  sequence s_no_src;
    (i_power_down || (i_rtc_source_select_bit && !i_crystal_path_enable_bit)) [*6];
  endsequence

  a_rst_quiet: assert property (disable iff (1'b0) i_rst |=>
    !o_trim_valid && !o_cal_busy && !o_rtc_tick && !o_freq_done && !o_freq_ok)
    else $error("output active after reset");
  a_trim_drop: assert property (s_rc_off |-> !o_trim_valid)
    else $error("trim kept with RC off");
  a_tick_pulse: assert property (o_rtc_tick |=> !o_rtc_tick)
    else $error("tick longer than one cycle");
  a_no_src_tick: assert property (s_no_src |-> !o_rtc_tick)
    else $error("tick without clock source");
  a_busy_cs: assert property (!i_cs [*6] |-> !o_cal_busy)
    else $error("busy without chip select");
  a_busy_start: assert property ($rose(o_cal_busy) |-> $past(i_cs, 8))
    else $error("busy before command");
  a_trim_end: assert property ($rose(o_trim_valid) |-> $fell(o_cal_busy))
    else $error("trim valid outside calibration end");
  a_trim_hold: assert property (
    o_trim_valid && $past(o_trim_valid) && !$past(o_cal_busy) |-> $stable(o_trim_period))
    else $error("trim changed while held");
  a_done_pulse: assert property (o_freq_done |=> !o_freq_done)
    else $error("done longer than one cycle");
  a_eval_gate: assert property (!i_wake_eval [*4] |-> !o_freq_done && !o_freq_ok)
    else $error("verdict without evaluation");
endmodule : rtcc_chk

bind rtcc_top rtcc_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs),
  .i_rtc_source_select_bit(i_rtc_source_select_bit),
  .i_crystal_path_enable_bit(i_crystal_path_enable_bit),
  .i_power_down(i_power_down), .i_wake_eval(i_wake_eval), .o_rtc_tick(o_rtc_tick),
  .o_trim_valid(o_trim_valid), .o_trim_period(o_trim_period), .o_cal_busy(o_cal_busy),
  .o_freq_done(o_freq_done), .o_freq_ok(o_freq_ok));

// *** sim/rtcc_host_model.sv ***
// Host controller model: chip select, serial clock and data of a trim frame.
// Assumes the caller waits for run_cal to return before the next frame.
`timescale 1ns/1ps

module rtcc_host_model (
  output logic o_cs,
  output logic o_scl,
  output logic o_sdata
);
  initial begin
    o_cs = 1'b0;
    o_scl = 1'b0;
    o_sdata = 1'b1;
  end

  // ====
  // Serial clock stands low between frames; 200 ns per cycle
  task automatic pulse();
    #100 o_scl = 1'b1;
    #100 o_scl = 1'b0;
  endtask : pulse

  // Fewer than 65 reference cycles models a host quitting early
  task automatic run_cal(input logic [7:0] cmd, input int nref);
    // Caller returns on a falling edge, so every pin moves on one too
    #25 o_cs = 1'b1;
    #200;
    for (int i = 7; i >= 0; i--) begin
      o_sdata = cmd[i];
      pulse();
    end
    o_sdata = ~o_sdata;
    for (int i = 0; i < nref; i++) pulse();
    #100 o_cs = 1'b0;
  endtask : run_cal
endmodule : rtcc_host_model

// *** sim/tb_top.sv ***
// Self-checking bench of the RTC source and RC trim block.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
`include "rtcc_params.svh"

module tb_top;
  logic clk, rst, cs, scl, sdat, xpin, car, sel, xen, pd, eval;
  logic tick, rclk, rc_on, tv, busy, fdone, fok, pv;
  logic [`RTCC_TRIM_W-1:0] tper;
  int err_total, cmp_count, xhalf, chalf, g, k, chg;
  bit busy_seen;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pin generators on a 50 ns grid, so none lands on a sampling edge
  always begin
    #50;
    if (xhalf != 0 && ($time % xhalf) == 0) xpin = ~xpin;
    if (chalf != 0 && ($time % chalf) == 0) car = ~car;
  end
  always @(posedge clk) if (busy === 1'b1) busy_seen <= 1'b1;

  rtcc_host_model host (.o_cs(cs), .o_scl(scl), .o_sdata(sdat));
  rtcc_top #(.RC_UNTRIMMED_CYC(40)) uut (.i_clk(clk), .i_rst(rst), .i_cs(cs),
    .i_scl(scl), .i_sdata(sdat), .i_crystal_input_pin(xpin), .i_carrier(car),
    .i_rtc_source_select_bit(sel), .i_crystal_path_enable_bit(xen),
    .i_power_down(pd), .i_wake_eval(eval), .o_rtc_tick(tick), .o_rtc_clk(rclk),
    .o_rc_on(rc_on), .o_trim_valid(tv), .o_trim_period(tper), .o_cal_busy(busy),
    .o_freq_done(fdone), .o_freq_ok(fok));

  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Cycles between two ticks; the first gap may be partial, so take two
  task automatic gap2();
    repeat (2) begin
      g = 0;
      do begin
        @(negedge clk);
        g++;
      end while (tick !== 1'b1 && g < 3000);
    end
  endtask : gap2

  // Counts ticks and changes of the RTC clock output over c cycles
  task automatic nticks(input int c);
    k = 0;
    chg = 0;
    pv = rclk;
    repeat (c) begin
      @(negedge clk);
      if (tick === 1'b1) k++;
      if (rclk !== pv) chg++;
      pv = rclk;
    end
  endtask : nticks

  // First window after evaluation starts gives no verdict; use the third
  task automatic win(input logic exp);
    k = 0;
    for (int n = 0; n < 9000 && k < 3; n++) begin
      @(negedge clk);
      if (fdone === 1'b1) k++;
    end
    chk("windows", 16'(k), 16'h0003);
    chk("freq_ok", fok, exp);
  endtask : win

  task automatic cal(input logic [7:0] cmd, input int nref);
    busy_seen = 1'b0;
    host.run_cal(cmd, nref);
    repeat (4) @(negedge clk);
  endtask : cal

  // ====
  // Scenarios
  task automatic t_reset();
    chk("trim_valid", tv, 1'h0);
    chk("cal_busy", busy, 1'h0);
    chk("rc_on", rc_on, 1'h1);
    gap2();
    chk("rc_gap", 16'(g), 16'h0028);
    nticks(400);
    chk("rc_ticks", 16'(k), 16'h000A);
    chk("rtc_clk_toggles", 16'(chg), 16'h000A);
  endtask : t_reset

  task automatic t_cal();
    cal(8'hC2, 65);
    chk("busy_seen", busy_seen, 1'h1);
    chk("trim_valid", tv, 1'h1);
    chk("trim_period", tper, 16'h0008);
    gap2();
    chk("trim_gap", 16'(g), 16'h0008);
    cal(8'h55, 65);
    chk("bad_cmd_busy", busy_seen, 1'h0);
    cal(8'hC2, 30);
    chk("abort_busy", busy_seen, 1'h1);
    chk("abort_valid", tv, 1'h1);
    chk("abort_period", tper, 16'h0008);
  endtask : t_cal

  task automatic t_xtal();
    sel = 1'b1;
    xen = 1'b1;
    xhalf = 400;
    repeat (6) @(negedge clk);
    chk("trim_dropped", tv, 1'h0);
    gap2();
    chk("xtal_gap", 16'(g), 16'h0020);
    eval = 1'b1;
    chalf = 100;
    win(1'b1);
    chalf = 50;
    win(1'b0);
    eval = 1'b0;
    chalf = 0;
    xen = 1'b0;
    nticks(200);
    chk("xtal_off_ticks", 16'(k), 16'h0000);
  endtask : t_xtal

  task automatic t_pd();
    sel = 1'b0;
    xen = 1'b1;
    pd = 1'b1;
    xhalf = 0;
    xpin = 1'b1;
    nticks(300);
    chk("pd_ticks", 16'(k), 16'h0000);
    chk("pd_rtc_clk", 16'(chg), 16'h0000);
    chk("pd_rc_on", rc_on, 1'h0);
    pd = 1'b0;
    cal(8'hC2, 65);
    chk("recal_valid", tv, 1'h1);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("rst_valid", tv, 1'h0);
  endtask : t_pd

  initial begin
    {rst, sel, xen, pd, eval, xpin, car} = 7'h40;
    {xhalf, chalf, err_total, cmp_count} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_cal();
    t_xtal();
    t_pd();
    end_sim();
  end

  // Whole run needs about 86 us
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : tb_top
